// >>> design/bsfm_top.sv
// Boost startup sequencer, fault monitor and status registers
`timescale 1ns/10ps
module bsfm_top #(
  parameter longint unsigned WDOG_CYCLES = bsfm_pkg::WDOG_CYC,
  parameter int unsigned FIRST_RETRY_CYCLES = bsfm_pkg::FIRST_RETRY_CYC,
  parameter int unsigned RETRY_CYCLES = bsfm_pkg::RETRY_CYC
) (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic host_port_boost_pin,
  input wire logic pin_boost_enable,
  input wire bsfm_pkg::bsfm_sense_s sense,
  input wire bsfm_pkg::bsfm_reg_req_s reg_req,
  output logic [7:0] reg_rdata,
  output bsfm_pkg::bsfm_drive_s drive,
  output logic boost_run_state
);
  import bsfm_pkg::*;

  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    bsfm_state_e fsm;
    logic high_z_bit;
    logic boost_request_bit;
    logic aux_out_disable;
    logic [2:0] fault;
    logic pin_started;
    logic [CNT_W-1:0] stat_cnt;
    logic [CNT_W-1:0] ilim_cnt;
    logic [39:0] wdog_cnt;
    logic retry_first;
    logic [7:0] rdata;
    bsfm_drive_s drv;
    logic run_flag;
  } bsfm_top_s;

  bsfm_top_s st_reg;
  bsfm_top_s st_next;

  logic tmr_load;
  logic [CNT_W-1:0] tmr_val;
  logic tmr_abort;
  logic tmr_expired;

  bsfm_timer #(
    .W(CNT_W)
  ) u_timer (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .load(tmr_load),
    .load_val(tmr_val),
    .abort(tmr_abort),
    .expired(tmr_expired)
  );

  function automatic logic [CNT_W-1:0] cyc(input int unsigned c);
    return CNT_W'(c);
  endfunction

  // ****************************************
  // Combinational decode
  // ****************************************
  logic pin_en;
  logic reg_en;
  logic boost_en;
  logic in_boost;
  logic [7:0] mon;
  logic fault_now;
  logic [2:0] fault_code;
  logic bat_cmp;

  always_comb begin
    pin_en = pin_boost_enable & host_port_boost_pin;
    reg_en = st_reg.boost_request_bit & ~st_reg.high_z_bit;
    // Pin enable overrides the high-z bit
    boost_en = pin_en | reg_en;
    in_boost = (st_reg.fsm != ST_OFF) && (st_reg.fsm != ST_WAIT);

    // Threshold chosen by mode
    if (in_boost) begin
      bat_cmp = sense.bat_above_uvlo;
    end else if (st_reg.high_z_bit) begin
      bat_cmp = sense.bat_above_lowv;
    end else begin
      bat_cmp = sense.bat_above_short;
    end

    // Raw unqualified status
    mon = {sense.termination_comparator, bat_cmp,
           sense.linear_charge_flag, sense.die_above_120,
           sense.charge_loop_flag, sense.input_limit_flag,
           sense.bus_valid_flag, sense.const_voltage_flag};

    // Priority: thermal, battery, overvoltage, startup
    fault_code = FLT_NONE;
    if (in_boost) begin
      if (sense.die_hot_shutdown) begin
        fault_code = FLT_THERMAL;
      end else if (!sense.bat_above_uvlo) begin
        fault_code = FLT_BAT_UV;
      end else if (sense.bus_ovp) begin
        fault_code = FLT_BUS_OV;
      end else if (tmr_expired &&
                   (st_reg.fsm == ST_LIN || st_reg.fsm == ST_SS2)) begin
        fault_code = FLT_SOFTSTART;
      end else if (st_reg.fsm == ST_RUN && sense.peak_ilim &&
                   st_reg.ilim_cnt >= cyc(ILIM_CYC)) begin
        fault_code = FLT_SOFTSTART;
      end
    end
    fault_now = fault_code != FLT_NONE;
  end

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    st_next = st_reg;
    tmr_load = 1'b0;
    tmr_val = '0;
    tmr_abort = 1'b0;
    st_next.rdata = st_reg.rdata;

    // Register writes
    if (reg_req.wr) begin
      unique case (reg_req.addr)
        CTRL0_ADDR: begin
          if (reg_req.wdata[CTRL0_KICK_BIT]) begin
            st_next.wdog_cnt = '0;
          end
        end
        CTRL1_ADDR: begin
          st_next.high_z_bit = reg_req.wdata[CTRL1_HIGHZ_BIT];
          st_next.boost_request_bit = reg_req.wdata[CTRL1_REQ_BIT];
        end
        SPCHG_ADDR: begin
          st_next.aux_out_disable = reg_req.wdata[SPCHG_AUXDIS_BIT];
        end
        default: begin
        end
      endcase
    end

    // Register reads
    if (reg_req.rd) begin
      unique case (reg_req.addr)
        CTRL0_ADDR: begin
          st_next.rdata = {1'b0, host_port_boost_pin, 2'b00,
                           in_boost, st_reg.fault};
          // Reading the fault field clears it
          st_next.fault = FLT_NONE;
        end
        CTRL1_ADDR: begin
          st_next.rdata = {6'h0c, st_reg.high_z_bit,
                           st_reg.boost_request_bit};
        end
        SPCHG_ADDR: begin
          st_next.rdata = {1'b0, st_reg.aux_out_disable, 6'h00};
        end
        MON_ADDR: st_next.rdata = mon;
        default: st_next.rdata = 8'h00;
      endcase
    end

    // Sustained current limit count in run state
    if (st_reg.fsm == ST_RUN && sense.peak_ilim) begin
      if (st_reg.ilim_cnt < cyc(ILIM_CYC)) begin
        st_next.ilim_cnt = st_reg.ilim_cnt + cyc(1);
      end
    end else begin
      st_next.ilim_cnt = '0;
    end

    // Status pulse stretch
    if (st_reg.stat_cnt != '0) begin
      st_next.stat_cnt = st_reg.stat_cnt - cyc(1);
    end

    // Watchdog runs only while boosting
    if (in_boost && !(reg_req.wr && reg_req.addr == CTRL0_ADDR &&
                      reg_req.wdata[CTRL0_KICK_BIT])) begin
      st_next.wdog_cnt = st_reg.wdog_cnt + 40'(1);
    end else if (!in_boost) begin
      st_next.wdog_cnt = '0;
    end

    unique case (st_reg.fsm)
      ST_OFF: begin
        if (boost_en && sense.bat_above_uvlo) begin
          st_next.fsm = ST_LIN;
          st_next.pin_started = pin_en;
          tmr_load = 1'b1;
          tmr_val = cyc(LIN_CYC);
        end
      end
      ST_LIN: begin
        if (sense.mid_above_bat_m400 && !fault_now) begin
          st_next.fsm = ST_SS1;
          tmr_load = 1'b1;
          tmr_val = cyc(SS1_CYC);
        end
      end
      ST_SS1: begin
        if (sense.bus_within_5pct) begin
          st_next.fsm = ST_RUN;
          tmr_abort = 1'b1;
        end else if (tmr_expired) begin
          st_next.fsm = ST_SS2;
          tmr_load = 1'b1;
          tmr_val = cyc(SS2_CYC);
        end
      end
      ST_SS2: begin
        if (sense.bus_within_5pct && !fault_now) begin
          st_next.fsm = ST_RUN;
          tmr_abort = 1'b1;
        end
      end
      ST_RUN: begin
      end
      ST_WAIT: begin
        if (!pin_en) begin
          st_next.fsm = ST_OFF;
          tmr_abort = 1'b1;
        end else if (tmr_expired) begin
          st_next.fsm = ST_LIN;
          st_next.pin_started = 1'b1;
          tmr_load = 1'b1;
          tmr_val = cyc(LIN_CYC);
        end
      end
      default: begin
        st_next.fsm = ST_OFF;
      end
    endcase

    // Disable while running: back to off, counting aborted
    if (in_boost && !boost_en) begin
      st_next.fsm = ST_OFF;
      st_next.boost_request_bit = 1'b0;
      tmr_abort = 1'b1;
    end else if (fault_now) begin
      st_next.fault = fault_code;
      st_next.boost_request_bit = 1'b0;
      st_next.stat_cnt = cyc(STAT_CYC);
      if (st_reg.pin_started && pin_en) begin
        st_next.fsm = ST_WAIT;
        tmr_load = 1'b1;
        tmr_val = st_reg.retry_first ? cyc(RETRY_CYCLES) :
                  cyc(FIRST_RETRY_CYCLES);
        st_next.retry_first = 1'b1;
      end else begin
        st_next.fsm = ST_OFF;
        tmr_abort = 1'b1;
      end
    end

    if (st_reg.fsm == ST_RUN && st_next.fsm == ST_RUN) begin
      st_next.retry_first = 1'b0;
    end
    if (!pin_en) begin
      st_next.retry_first = 1'b0;
    end

    // Watchdog expiry: control bits back to reset values, fault field set to FLT_TIMER
    if (in_boost && st_reg.wdog_cnt >= 40'(WDOG_CYCLES)) begin
      st_next.fsm = ST_OFF;
      st_next.high_z_bit = CTRL1_RESET[CTRL1_HIGHZ_BIT];
      st_next.boost_request_bit = 1'b0;
      st_next.aux_out_disable = SPCHG_RESET[SPCHG_AUXDIS_BIT];
      st_next.fault = FLT_TIMER;
      st_next.stat_cnt = cyc(STAT_CYC);
      st_next.wdog_cnt = '0;
      st_next.retry_first = 1'b0;
      tmr_abort = 1'b1;
    end

    // Power stage outputs, from the next state
    st_next.drv.block_bat_bus = (st_next.fsm == ST_OFF) ||
                                (st_next.fsm == ST_WAIT);
    st_next.drv.stage_high_z = st_next.drv.block_bat_bus;
    st_next.drv.lin_source_en = st_next.fsm == ST_LIN;
    st_next.drv.ilim_half = st_next.fsm == ST_SS1;
    st_next.drv.loop_closed = st_next.fsm == ST_RUN;
    st_next.drv.switch_en = (st_next.fsm == ST_SS1) ||
                            (st_next.fsm == ST_SS2) ||
                            (st_next.fsm == ST_RUN &&
                             !sense.fb_above_ref);
    st_next.drv.aux_regulator_en = sense.mid_above_bat &&
                                   !st_next.drv.switch_en &&
                                   st_next.drv.block_bat_bus &&
                                   !st_next.high_z_bit &&
                                   !st_next.aux_out_disable;
    st_next.drv.stat_pulse = st_next.stat_cnt != '0;
    st_next.run_flag = st_next.fsm == ST_RUN;
  end

  // ****************************************
  // Registers
  // ****************************************
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      st_reg <= '0;
      st_reg.fsm <= ST_OFF;
      st_reg.high_z_bit <= CTRL1_RESET[CTRL1_HIGHZ_BIT];
      st_reg.boost_request_bit <= CTRL1_RESET[CTRL1_REQ_BIT];
      st_reg.aux_out_disable <= SPCHG_RESET[SPCHG_AUXDIS_BIT];
      st_reg.drv.block_bat_bus <= 1'b1;
      st_reg.drv.stage_high_z <= 1'b1;
    end else begin
      st_reg <= st_next;
    end
  end

  assign reg_rdata = st_reg.rdata;
  assign drive = st_reg.drv;
  assign boost_run_state = st_reg.run_flag;
endmodule

// >>> design/bsfm_pkg.sv
// Package: constants, states and carriers of the boost startup fault monitor
package bsfm_pkg;

  // ****************************************
  // Clock and timing
  // ****************************************
  localparam int unsigned CLK_HZ = 25_000_000;
  localparam int unsigned LIN_TIMEOUT_US = 560;
  localparam int unsigned SS1_TIMEOUT_US = 128;
  localparam int unsigned SS2_TIMEOUT_US = 384;
  localparam int unsigned ILIM_SUSTAIN_US = 50;
  localparam int unsigned FIRST_RETRY_US = 5200;
  localparam int unsigned RETRY_US = 5000;
  localparam int unsigned STAT_PULSE_US = 128;
  localparam int unsigned WDOG_S = 32;

  // Times convert exactly at a whole-MHz clock, none below one cycle
  function automatic int unsigned us_to_cyc(input int unsigned us);
    int unsigned c;
    c = (CLK_HZ / 1_000_000) * us;
    return (c == 0) ? 1 : c;
  endfunction

  localparam int unsigned LIN_CYC = us_to_cyc(LIN_TIMEOUT_US);
  localparam int unsigned SS1_CYC = us_to_cyc(SS1_TIMEOUT_US);
  localparam int unsigned SS2_CYC = us_to_cyc(SS2_TIMEOUT_US);
  localparam int unsigned ILIM_CYC = us_to_cyc(ILIM_SUSTAIN_US);
  localparam int unsigned STAT_CYC = us_to_cyc(STAT_PULSE_US);
  localparam int unsigned FIRST_RETRY_CYC = us_to_cyc(FIRST_RETRY_US);
  localparam int unsigned RETRY_CYC = us_to_cyc(RETRY_US);
  localparam longint unsigned WDOG_CYC = longint'(CLK_HZ) * WDOG_S;

  localparam int CNT_W = 32;

  // ****************************************
  // Register map
  // ****************************************
  localparam logic [7:0] CTRL0_ADDR = 8'h00;
  localparam logic [7:0] CTRL1_ADDR = 8'h01;
  localparam logic [7:0] SPCHG_ADDR = 8'h05;
  localparam logic [7:0] MON_ADDR = 8'h10;
  localparam int CTRL0_KICK_BIT = 7;
  localparam int CTRL0_BOOST_BIT = 3;
  localparam int CTRL0_FAULT_LSB = 0;
  localparam int CTRL1_HIGHZ_BIT = 1;
  localparam int CTRL1_REQ_BIT = 0;
  localparam int SPCHG_AUXDIS_BIT = 6;
  localparam logic [7:0] CTRL1_RESET = 8'h30;
  localparam logic [7:0] SPCHG_RESET = 8'h00;

  // ****************************************
  // Boost fault codes
  // ****************************************
  localparam logic [2:0] FLT_NONE = 3'h0;
  localparam logic [2:0] FLT_BUS_OV = 3'h1;
  localparam logic [2:0] FLT_SOFTSTART = 3'h2;
  localparam logic [2:0] FLT_BAT_UV = 3'h3;
  localparam logic [2:0] FLT_THERMAL = 3'h5;
  localparam logic [2:0] FLT_TIMER = 3'h6;

  typedef enum logic [2:0] {
    ST_OFF = 3'b000,
    ST_LIN = 3'b001,
    ST_SS1 = 3'b010,
    ST_SS2 = 3'b011,
    ST_RUN = 3'b100,
    ST_WAIT = 3'b101
  } bsfm_state_e;

  // Analog comparator results
  typedef struct packed {
    logic mid_above_bat_m400;
    logic mid_above_bat;
    logic bus_within_5pct;
    logic bus_ovp;
    logic bat_above_uvlo;
    logic bat_above_short;
    logic bat_above_lowv;
    logic die_hot_shutdown;
    logic die_above_120;
    logic fb_above_ref;
    logic peak_ilim;
    logic termination_comparator;
    logic linear_charge_flag;
    logic charge_loop_flag;
    logic input_limit_flag;
    logic bus_valid_flag;
    logic const_voltage_flag;
  } bsfm_sense_s;

  // Power stage drives
  typedef struct packed {
    logic block_bat_bus;
    logic lin_source_en;
    logic switch_en;
    logic ilim_half;
    logic loop_closed;
    logic stage_high_z;
    logic aux_regulator_en;
    logic stat_pulse;
  } bsfm_drive_s;

  // Register port from the serial engine
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } bsfm_reg_req_s;

endpackage

// >>> design/bsfm_timer.sv
// Reloadable down-counter used for every startup and retry interval
`timescale 1ns/10ps
module bsfm_timer #(
  parameter int W = 32
) (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic load,
  input wire logic [W-1:0] load_val,
  input wire logic abort,
  output logic expired
);
  typedef struct packed {
    logic [W-1:0] cnt;
    logic run;
    logic done;
  } bsfm_timer_s;

  bsfm_timer_s st_reg;
  bsfm_timer_s st_next;

  always_comb begin
    st_next = st_reg;
    st_next.done = 1'b0;
    if (abort) begin
      st_next.run = 1'b0;
      st_next.cnt = '0;
    end else if (load) begin
      st_next.run = 1'b1;
      st_next.cnt = load_val;
    end else if (st_reg.run) begin
      if (st_reg.cnt <= W'(1)) begin
        st_next.run = 1'b0;
        st_next.done = 1'b1;
      end else begin
        st_next.cnt = st_reg.cnt - W'(1);
      end
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign expired = st_reg.done;
endmodule

// >>> verif/bsfm_assertions.sv
// Port checker for the boost startup fault monitor
`timescale 1ns/10ps
module bsfm_assertions import bsfm_pkg::*; (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic host_port_boost_pin,
  input wire logic pin_boost_enable,
  input wire bsfm_pkg::bsfm_sense_s sense,
  input wire bsfm_pkg::bsfm_reg_req_s reg_req,
  input wire logic [7:0] reg_rdata,
  input wire bsfm_pkg::bsfm_drive_s drive,
  input wire logic boost_run_state
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  logic [15:0] lin_cnt;
  logic [15:0] stat_cnt;
  logic hz_q;
  logic [7:0] mon_raw;
  // Mode-dependent battery bit left out
  always_comb begin
    mon_raw = {sense.termination_comparator, 1'b0, sense.linear_charge_flag,
      sense.die_above_120, sense.charge_loop_flag, sense.input_limit_flag,
      sense.bus_valid_flag, sense.const_voltage_flag};
  end
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      lin_cnt <= '0;
      stat_cnt <= '0;
      hz_q <= 1'b1;
    end else begin
      lin_cnt <= drive.lin_source_en ? lin_cnt + 16'h1 : '0;
      hz_q <= drive.stage_high_z;
      // A new fault restarts the stretch, so retries merge pulses
      if (!drive.stat_pulse) begin
        stat_cnt <= '0;
      end else if (drive.stage_high_z && !hz_q) begin
        stat_cnt <= 16'h1;
      end else begin
        stat_cnt <= stat_cnt + 16'h1;
      end
    end
  end
  property p_off_blocks;
    drive.stage_high_z |-> drive.block_bat_bus && !drive.switch_en;
  endproperty
  a_off_blocks: assert property (p_off_blocks)
    else $error("stage off but path open");
  property p_lin_limit;
    lin_cnt <= LIN_CYC + 2;
  endproperty
  a_lin_limit: assert property (p_lin_limit)
    else $error("linear precharge outlived its limit");
  property p_half_open;
    drive.ilim_half |-> !drive.loop_closed && !boost_run_state;
  endproperty
  a_half_open: assert property (p_half_open)
    else $error("half limit with loop closed");
  property p_run_full;
    boost_run_state && $past(boost_run_state) |->
      drive.loop_closed && !drive.ilim_half;
  endproperty
  a_run_full: assert property (p_run_full)
    else $error("run state without full limit");
  property p_fb_off;
    boost_run_state && $past(boost_run_state) && sense.fb_above_ref &&
      $past(sense.fb_above_ref) |-> !drive.switch_en;
  endproperty
  a_fb_off: assert property (p_fb_off)
    else $error("switch on above reference");
  property p_fault_hz;
    $rose(drive.stat_pulse) |-> ##[0:2] drive.stage_high_z;
  endproperty
  a_fault_hz: assert property (p_fault_hz)
    else $error("fault pulse without high impedance");
  property p_stat_len;
    stat_cnt <= STAT_CYC;
  endproperty
  a_stat_len: assert property (p_stat_len)
    else $error("status pulse too long");
  property p_codes;
    reg_req.rd && reg_req.addr == CTRL0_ADDR |=>
      reg_rdata[2:0] != 3'h4 && reg_rdata[2:0] != 3'h7;
  endproperty
  a_codes: assert property (p_codes)
    else $error("unused fault code reported");
  property p_aux_off;
    drive.aux_regulator_en |-> !boost_run_state && !drive.switch_en;
  endproperty
  a_aux_off: assert property (p_aux_off)
    else $error("aux output on during boost");
  property p_mon;
    reg_req.rd && reg_req.addr == MON_ADDR |=>
      (reg_rdata & 8'hbf) == $past(mon_raw);
  endproperty
  a_mon: assert property (p_mon)
    else $error("monitor read not raw status");
  c_run: cover property (boost_run_state);
  c_fault: cover property ($rose(drive.stat_pulse));
  c_aux: cover property ($rose(drive.aux_regulator_en));
endmodule

// >>> verif/bsfm_host.sv
// Host model driving the register port in the serial engine's place
`timescale 1ns/10ps
module bsfm_host import bsfm_pkg::*; (
  input wire logic clk_sys,
  input wire logic [7:0] reg_rdata,
  output bsfm_pkg::bsfm_reg_req_s reg_req
);
  initial reg_req = '0;
  // Idle bus parks on inverted values so stale bytes never look valid
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_req <= '{1'b1, 1'b0, a, d};
    @(posedge clk_sys);
    reg_req <= '{1'b0, 1'b0, ~a, ~d};
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_sys);
    reg_req <= '{1'b0, 1'b1, a, 8'h00};
    @(posedge clk_sys);
    reg_req <= '{1'b0, 1'b0, ~a, 8'hff};
    @(posedge clk_sys);
    #1 d = reg_rdata;
  endtask
endmodule

// >>> verif/test_boost_startup_fault_monitor.sv
// Self-checking bench for the boost startup fault monitor
`timescale 1ns/10ps
module test_boost_startup_fault_monitor;
  import bsfm_pkg::*;
  localparam int FR = 200;
  localparam int RT = 150;
  // Watchdog outlasts the linear and soft-start timeout paths the bench drives
  localparam int WD = 16000;
  logic clk_sys, sys_rst, host_port_boost_pin, pin_boost_enable;
  bsfm_sense_s sense;
  bsfm_reg_req_s reg_req;
  logic [7:0] reg_rdata, rb;
  bsfm_drive_s drive;
  logic boost_run_state;
  int n_errors, tests_run, n, k;
  bsfm_top #(.WDOG_CYCLES(WD), .FIRST_RETRY_CYCLES(FR),
    .RETRY_CYCLES(RT)) i_dut (.clk_sys, .sys_rst, .host_port_boost_pin,
    .pin_boost_enable, .sense, .reg_req, .reg_rdata, .drive,
    .boost_run_state);
  bsfm_host i_host (.clk_sys, .reg_rdata, .reg_req);
  initial begin
    clk_sys = 0;
    forever #20 clk_sys = ~clk_sys;
  end
  task automatic check(string what, logic [15:0] seen, logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value %s: expected %h seen %h", what, exp, seen);
    end
  endtask
  function automatic logic sel(int w);
    case (w)
      0: return drive.lin_source_en;
      1: return drive.ilim_half;
      2: return drive.stage_high_z;
      default: return boost_run_state;
    endcase
  endfunction
  // Cycles until the chosen output reaches lvl; lim if it never does
  task automatic wait_for(int w, logic lvl, int lim, output int c);
    for (c = 0; c < lim; c++) begin
      @(posedge clk_sys);
      #1;
      if (sel(w) === lvl) break;
    end
  endtask
  task automatic start_run;
    i_host.wr(CTRL1_ADDR, 8'h01);
    wait_for(3, 1'b1, 100, n);
  endtask
  task automatic results;
    $display("comparisons %0d mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  initial begin
    repeat (80000) @(posedge clk_sys);
    n_errors++;
    results();
  end
  initial begin
    sys_rst = 1;
    host_port_boost_pin = 0;
    pin_boost_enable = 0;
    sense = '0;
    sense.bat_above_uvlo = 1;
    sense.mid_above_bat_m400 = 1;
    sense.bus_within_5pct = 1;
    repeat (4) @(posedge clk_sys);
    #1 check("drive in reset", drive, 8'h84);
    @(posedge clk_sys) sys_rst <= 0;
    start_run();
    check("run loop", {drive.loop_closed, drive.ilim_half}, 2'b10);
    @(posedge clk_sys) sense.fb_above_ref <= 1;
    repeat (3) @(posedge clk_sys);
    #1 check("switch high fb", drive.switch_en, 0);
    @(posedge clk_sys) sense.fb_above_ref <= 0;
    repeat (3) @(posedge clk_sys);
    #1 check("switch low fb", drive.switch_en, 1);
    i_host.rd(CTRL0_ADDR, rb);
    check("boost bit", rb[3], 1);
    i_host.rd(MON_ADDR, rb);
    check("monitor boost", rb, 8'h40);
    i_host.wr(CTRL1_ADDR, 8'h03);
    wait_for(2, 1'b1, 20, n);
    i_host.rd(CTRL1_ADDR, rb);
    check("hz clears request", rb, 8'h32);
    check("off path", {drive.block_bat_bus, drive.switch_en}, 2'b10);
    i_host.wr(CTRL1_ADDR, 8'h00);
    $display("test normal path done");
    @(posedge clk_sys) sense.mid_above_bat_m400 <= 0;
    i_host.wr(CTRL1_ADDR, 8'h01);
    wait_for(0, 1'b1, 10, n);
    wait_for(0, 1'b0, LIN_CYC + 10, n);
    check("lin time", n > LIN_CYC - 4 && n < LIN_CYC + 3, 1);
    i_host.rd(CTRL0_ADDR, rb);
    check("lin code", rb[2:0], FLT_SOFTSTART);
    check("stat pulse", drive.stat_pulse, 1);
    i_host.rd(CTRL1_ADDR, rb);
    check("fault clears request", rb, 8'h30);
    repeat (FR + 20) @(posedge clk_sys);
    #1 check("no restart", drive.lin_source_en, 0);
    $display("test linear timeout done");
    @(posedge clk_sys) begin
      sense.mid_above_bat_m400 <= 1;
      sense.bus_within_5pct <= 0;
    end
    i_host.wr(CTRL1_ADDR, 8'h01);
    wait_for(1, 1'b1, 20, n);
    wait_for(1, 1'b0, SS1_CYC + 10, n);
    check("ss1 time", n > SS1_CYC - 4 && n < SS1_CYC + 3, 1);
    check("still trying", drive.stage_high_z, 0);
    wait_for(2, 1'b1, SS2_CYC + 10, n);
    check("ss2 time", n > SS2_CYC - 4 && n < SS2_CYC + 3, 1);
    i_host.rd(CTRL0_ADDR, rb);
    check("ss code", rb[2:0], FLT_SOFTSTART);
    @(posedge clk_sys) sense.bus_within_5pct <= 1;
    $display("test soft-start timeout done");
    for (k = 0; k < 4; k++) begin
      start_run();
      @(posedge clk_sys) case (k)
        0: sense.bus_ovp <= 1;
        1: sense.bat_above_uvlo <= 0;
        2: sense.die_hot_shutdown <= 1;
        default: sense.peak_ilim <= 1;
      endcase
      wait_for(2, 1'b1, ILIM_CYC + 20, n);
      i_host.rd(CTRL0_ADDR, rb);
      case (k)
        0: check("ovp code", rb[2:0], FLT_BUS_OV);
        1: check("uv code", rb[2:0], FLT_BAT_UV);
        2: check("hot code", rb[2:0], FLT_THERMAL);
        default: check("ilim code", rb[2:0], FLT_SOFTSTART);
      endcase
      @(posedge clk_sys) begin
        sense.bus_ovp <= 0;
        sense.bat_above_uvlo <= 1;
        sense.die_hot_shutdown <= 0;
        sense.peak_ilim <= 0;
      end
    end
    $display("test fault codes done");
    start_run();
    repeat (1000) @(posedge clk_sys);
    i_host.wr(CTRL0_ADDR, 8'h80);
    wait_for(2, 1'b1, WD + 100, n);
    check("kick extends", n > WD - 10 && n < WD + 5, 1);
    i_host.rd(CTRL0_ADDR, rb);
    check("timer code", rb[2:0], FLT_TIMER);
    i_host.rd(CTRL1_ADDR, rb);
    check("regs reset", rb, 8'h30);
    $display("test watchdog done");
    @(posedge clk_sys) begin
      sense.die_hot_shutdown <= 1;
      pin_boost_enable <= 1;
      host_port_boost_pin <= 1;
    end
    wait_for(0, 1'b1, 20, n);
    wait_for(0, 1'b0, 20, n);
    wait_for(0, 1'b1, FR + 10, n);
    check("first retry", n > FR - 4 && n < FR + 3, 1);
    wait_for(0, 1'b0, 20, n);
    wait_for(0, 1'b1, RT + 10, n);
    check("next retry", n > RT - 4 && n < RT + 3, 1);
    @(posedge clk_sys) host_port_boost_pin <= 0;
    wait_for(0, 1'b1, RT + 20, n);
    check("pin off stops retry", n, RT + 20);
    @(posedge clk_sys) begin
      sense.die_hot_shutdown <= 0;
      pin_boost_enable <= 0;
      sense.mid_above_bat <= 1;
    end
    i_host.rd(CTRL0_ADDR, rb);
    $display("test retry done");
    repeat (3) @(posedge clk_sys);
    #1 check("aux on", drive.aux_regulator_en, 1);
    i_host.wr(SPCHG_ADDR, 8'h40);
    repeat (2) @(posedge clk_sys);
    #1 check("aux disabled", drive.aux_regulator_en, 0);
    i_host.wr(SPCHG_ADDR, 8'h00);
    i_host.wr(CTRL1_ADDR, 8'h02);
    repeat (2) @(posedge clk_sys);
    #1 check("aux high-z", drive.aux_regulator_en, 0);
    @(posedge clk_sys) begin
      sense.termination_comparator <= 1;
      sense.die_above_120 <= 1;
      sense.bus_valid_flag <= 1;
      sense.bat_above_short <= 1;
    end
    // Battery bit clear in high-z because bat_above_lowv is not set
    i_host.rd(MON_ADDR, rb);
    check("monitor high-z", rb, 8'h92);
    i_host.wr(CTRL1_ADDR, 8'h00);
    i_host.rd(MON_ADDR, rb);
    check("monitor charge", rb, 8'hd2);
    i_host.rd(8'h3f, rb);
    check("unmapped read", rb, 8'h00);
    $display("test aux and monitor done");
    results();
  end
endmodule
bind bsfm_top bsfm_assertions i_chk (.clk_sys, .sys_rst,
  .host_port_boost_pin, .pin_boost_enable, .sense, .reg_req, .reg_rdata,
  .drive, .boost_run_state);
